/* File: src/rtc_core.sv */
// rtc core: time registers, alarm page, pulse output, apb slave
`timescale 1ns/1ps
`default_nettype none
module rtc_core
  import rtc_pkg::*;
#(
  parameter int DIV = LS_DIV,
  parameter int PER_SEC = LS_PER_SEC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic alarm_n,
  output logic rtc_interrupt_n,
  output logic rtc_interrupt_request
);
  typedef struct packed {
    logic [5:0] sec;
    logic [6:0] min;
    logic [4:0] hour;
    logic [2:0] wday;
    logic [4:0] date;
    logic [6:0] a_min;
    logic [5:0] a_hour;
    logic [5:0] a_date;
    logic [2:0] a_wday;
    logic page;
    logic alarm_en;
    logic run;
    logic int_en;
    logic adjust;
    logic sec_rst;
    logic dis1;
    logic dis16;
    logic matched;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic alm_n;
    logic irq_n;
    logic irq;
    logic wr_pend;
    logic wr_page;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
  } st_s;
  st_s q, d;
  logic ls_tick, tick_1hz, tick_16hz;
  logic access, event_hit, match_now;
  // ------------------------------------------------------------
  // seconds prescaler
  // ------------------------------------------------------------
  rtc_sec_counter #(.DIV(DIV), .PER_SEC(PER_SEC)) u_sec (
    .clk(clk),
    .reset(reset),
    .clr(ls_tick && q.sec_rst),
    .ls_tick(ls_tick),
    .tick_1hz(tick_1hz),
    .tick_16hz(tick_16hz)
  );
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic is_off(input logic [7:0] a, input logic [7:0] o);
    is_off = (a == o);
  endfunction
  function automatic logic [7:0] wrap_inc(input logic [7:0] v,
                                          input logic [7:0] top,
                                          input logic [7:0] base);
    wrap_inc = (v >= top) ? base : v + 8'h01;
  endfunction
  assign access = psel && penable && !q.ready;
  assign match_now = (q.min == q.a_min) && ({1'b0, q.hour} == q.a_hour) &&
    ({1'b0, q.date} == q.a_date) && (q.wday == q.a_wday);
  always_comb begin
    event_hit = 1'b0;
    if (q.alarm_en) begin
      event_hit = match_now && !q.matched;
    end else if (!q.dis1 && q.dis16) begin
      event_hit = tick_1hz;
    end else if (q.dis1 && !q.dis16) begin
      event_hit = tick_16hz;
    end
  end
  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    d = q;
    d.ready = 1'b0;
    d.err = 1'b0;
    // requests consumed first, so a new write in the same cycle wins
    if (tick_1hz) begin
      d.adjust = 1'b0;
    end
    if (ls_tick && q.sec_rst) begin
      d.sec_rst = 1'b0;
    end
    // apb: time and alarm writes are latched, applied on the low-speed tick
    if (access) begin
      d.ready = 1'b1;
      d.rdata = 32'h0000_0000;
      if (pwrite) begin
        if (is_off(paddr, OFF_PAGE_CTRL)) begin
          d.page = pwdata[PG_PAGE];
          d.alarm_en = pwdata[PG_ALARM_EN];
          d.run = pwdata[PG_RUN];
          d.int_en = pwdata[PG_INT_EN];
          d.adjust = d.adjust | pwdata[PG_ADJUST];
        end else if (is_off(paddr, OFF_RTC_RESET)) begin
          d.dis1 = pwdata[RR_DIS1];
          d.dis16 = pwdata[RR_DIS16];
          d.sec_rst = d.sec_rst | pwdata[RR_SEC_RST];
          if (pwdata[RR_ALARM_RST]) begin
            d.a_min = ALM_MIN_RST;
            d.a_hour = ALM_HOUR_RST;
            d.a_date = ALM_DATE_RST;
            d.a_wday = ALM_DAY_RST;
          end
        end else if (paddr <= OFF_DATE && paddr[1:0] == 2'b00) begin
          d.wr_pend = 1'b1;
          d.wr_addr = paddr;
          d.wr_page = q.page;
          d.wr_data = pwdata[7:0];
        end else begin
          d.err = 1'b1;
        end
      end else begin
        if (is_off(paddr, OFF_PAGE_CTRL)) begin
          d.rdata = {24'h0, q.int_en, 2'b00, q.adjust, q.run,
                     q.alarm_en, 1'b0, q.page};
        end else if (is_off(paddr, OFF_RTC_RESET)) begin
          d.rdata = {24'h0, q.dis1, q.dis16, q.sec_rst, 5'h00};
        end else if (is_off(paddr, OFF_SECOND)) begin
          d.rdata = q.page ? 32'h0 : {26'h0, q.sec};
        end else if (is_off(paddr, OFF_MINUTE)) begin
          d.rdata = {25'h0, q.page ? q.a_min : q.min};
        end else if (is_off(paddr, OFF_HOUR)) begin
          d.rdata = {26'h0, q.page ? q.a_hour : {1'b0, q.hour}};
        end else if (is_off(paddr, OFF_WEEKDAY)) begin
          d.rdata = {29'h0, q.page ? q.a_wday : q.wday};
        end else if (is_off(paddr, OFF_DATE)) begin
          d.rdata = {26'h0, q.page ? q.a_date : {1'b0, q.date}};
        end else begin
          d.err = 1'b1;
        end
      end
    end
    // low-speed domain work
    if (ls_tick) begin
      d.irq_n = 1'b1;
      d.alm_n = 1'b1;
      d.irq = 1'b0;
      if (q.wr_pend && !(access && pwrite)) begin
        d.wr_pend = 1'b0;
        if (q.wr_page) begin
          if (is_off(q.wr_addr, OFF_MINUTE)) d.a_min = q.wr_data[6:0];
          if (is_off(q.wr_addr, OFF_HOUR)) d.a_hour = q.wr_data[5:0];
          if (is_off(q.wr_addr, OFF_WEEKDAY)) d.a_wday = q.wr_data[2:0];
          if (is_off(q.wr_addr, OFF_DATE)) d.a_date = q.wr_data[5:0];
        end else begin
          if (is_off(q.wr_addr, OFF_SECOND)) d.sec = q.wr_data[5:0];
          if (is_off(q.wr_addr, OFF_MINUTE)) d.min = q.wr_data[6:0];
          if (is_off(q.wr_addr, OFF_HOUR)) d.hour = q.wr_data[4:0];
          if (is_off(q.wr_addr, OFF_WEEKDAY)) d.wday = q.wr_data[2:0];
          if (is_off(q.wr_addr, OFF_DATE)) d.date = q.wr_data[4:0];
        end
      end
      if (!match_now) begin
        d.matched = 1'b0;
      end
      if (event_hit && q.int_en) begin
        d.alm_n = 1'b0;
        d.irq_n = 1'b0;
        d.irq = 1'b1;
        d.matched = q.alarm_en;
      end
    end
    // seconds count-up advances the time of day
    if (tick_1hz) begin
      if (q.run) begin
        if (q.adjust && q.sec < ADJ_HALF) begin
          d.sec = 6'd0;
        end else if (q.adjust || q.sec == 6'd59) begin
          d.sec = 6'd0;
          d.min = 7'(wrap_inc({1'b0, q.min}, 8'd59, 8'd0));
          if (q.min == 7'd59) begin
            d.hour = 5'(wrap_inc({3'b0, q.hour}, 8'd23, 8'd0));
            if (q.hour == 5'd23) begin
              d.wday = 3'(wrap_inc({5'b0, q.wday}, 8'd6, 8'd0));
              d.date = 5'(wrap_inc({3'b0, q.date}, 8'd31, 8'd1));
            end
          end
        end else begin
          d.sec = q.sec + 6'd1;
        end
      end
    end
    if (access) begin
      d.ready = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
      q.page <= PAGE_CTRL_RST[PG_PAGE];
      q.dis1 <= DIS1_RST;
      q.dis16 <= DIS16_RST;
      q.a_date <= ALM_DATE_RST;
      q.date <= 5'd1;
      q.alm_n <= 1'b1;
      q.irq_n <= 1'b1;
    end else begin
      q <= d;
    end
  end
  assign prdata = q.rdata;
  assign pready = q.ready;
  assign pslverr = q.err;
  assign alarm_n = q.alm_n;
  assign rtc_interrupt_n = q.irq_n;
  assign rtc_interrupt_request = q.irq;
endmodule
`default_nettype wire

/* File: src/rtc_pkg.sv */
// package: register map, field positions, reset values and timing counts
package rtc_pkg;
  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_SECOND = 8'h00;
  localparam logic [7:0] OFF_MINUTE = 8'h04;
  localparam logic [7:0] OFF_HOUR = 8'h08;
  localparam logic [7:0] OFF_WEEKDAY = 8'h0c;
  localparam logic [7:0] OFF_DATE = 8'h10;
  localparam logic [7:0] OFF_PAGE_CTRL = 8'h1c;
  localparam logic [7:0] OFF_RTC_RESET = 8'h20;
  // ------------------------------------------------------------
  // page control fields
  // ------------------------------------------------------------
  localparam int PG_PAGE = 0;
  localparam int PG_ALARM_EN = 2;
  localparam int PG_RUN = 3;
  localparam int PG_ADJUST = 4;
  localparam int PG_INT_EN = 7;
  localparam logic [7:0] PAGE_CTRL_RST = 8'h00;
  // ------------------------------------------------------------
  // reset register fields
  // ------------------------------------------------------------
  localparam int RR_ALARM_RST = 4;
  localparam int RR_SEC_RST = 5;
  localparam int RR_DIS16 = 6;
  localparam int RR_DIS1 = 7;
  localparam logic DIS1_RST = 1'b1;
  localparam logic DIS16_RST = 1'b1;
  // ------------------------------------------------------------
  // alarm reset values and adjust threshold
  // ------------------------------------------------------------
  localparam logic [6:0] ALM_MIN_RST = 7'h00;
  localparam logic [5:0] ALM_HOUR_RST = 6'h00;
  localparam logic [5:0] ALM_DATE_RST = 6'h01;
  localparam logic [2:0] ALM_DAY_RST = 3'h0;
  localparam logic [5:0] ADJ_HALF = 6'd30;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int LS_HZ = 32_768;
  localparam int LS_DIV = CLK_HZ / LS_HZ;
  localparam int LS_PER_SEC = LS_HZ;
  localparam int LS_PER_16HZ = LS_HZ / 16;
endpackage

/* File: src/rtc_sec_counter.sv */
// seconds prescaler: low-speed enable, 1 Hz and 16 Hz ticks
`timescale 1ns/1ps
`default_nettype none
module rtc_sec_counter
  import rtc_pkg::*;
#(
  parameter int DIV = LS_DIV,
  parameter int PER_SEC = LS_PER_SEC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clr,
  output logic ls_tick,
  output logic tick_1hz,
  output logic tick_16hz
);
  typedef struct packed {
    logic [15:0] div;
    logic [15:0] cnt;
    logic ls;
    logic t1;
    logic t16;
  } sc_s;
  sc_s q, d;
  localparam int PER_16 = PER_SEC / (LS_PER_SEC / LS_PER_16HZ);
  localparam logic [15:0] MASK_16 = 16'(PER_16 - 1);
  // ------------------------------------------------------------
  // prescaler
  // ------------------------------------------------------------
  // ticks are registered together with the low-speed enable so that
  // the core sees ls_tick, tick_1hz and tick_16hz in the same cycle
  always_comb begin
    d = q;
    d.ls = 1'b0;
    d.t1 = 1'b0;
    d.t16 = 1'b0;
    if (q.div == 16'(DIV - 1)) begin
      d.div = 16'h0000;
      d.ls = 1'b1;
      if (clr) begin
        d.cnt = 16'h0000;
      end else if (q.cnt == 16'(PER_SEC - 1)) begin
        d.cnt = 16'h0000;
        d.t1 = 1'b1;
      end else begin
        d.cnt = q.cnt + 16'h0001;
      end
      if (!clr && (q.cnt & MASK_16) == MASK_16) begin
        d.t16 = 1'b1;
      end
    end else begin
      d.div = q.div + 16'h0001;
      if (clr) begin
        d.cnt = 16'h0000;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign ls_tick = q.ls;
  assign tick_1hz = q.t1;
  assign tick_16hz = q.t16;
endmodule
`default_nettype wire

/* File: tb/rtc_core_monitor.sv */
// checker bound to the rtc core ports
`timescale 1ns/1ps
`default_nettype none
module rtc_core_monitor
  import rtc_pkg::*;
#(
  parameter int DIV = LS_DIV,
  parameter int PER_SEC = LS_PER_SEC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic alarm_n,
  input wire logic rtc_interrupt_n,
  input wire logic rtc_interrupt_request
);
  int low_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  always_ff @(posedge clk) begin
    if (reset || rtc_interrupt_n) begin
      low_q <= 0;
    end else begin
      low_q <= low_q + 1;
    end
  end
  // ----
  // assertions
  // ----
  chk_int_pair: assert property (
    !rtc_interrupt_n |-> rtc_interrupt_request)
    else $error("interrupt pin low without request");
  chk_req_pair: assert property (
    rtc_interrupt_request |-> !rtc_interrupt_n)
    else $error("request without interrupt pin low");
  chk_alarm_int: assert property (
    !alarm_n |-> !rtc_interrupt_n)
    else $error("alarm pulse without interrupt");
  chk_pulse_hold: assert property (
    $fell(rtc_interrupt_n) |=> !rtc_interrupt_n)
    else $error("interrupt pulse too short");
  chk_pulse_len: assert property (
    $rose(rtc_interrupt_n) |-> low_q == DIV)
    else $error("interrupt pulse not one low-speed period");
  chk_pulse_gap: assert property (
    $rose(rtc_interrupt_n) |-> rtc_interrupt_n [*8])
    else $error("interrupt pulses too close");
  chk_ready_wait: assert property (
    psel && penable && !pready |=> pready)
    else $error("access not answered after one wait");
  chk_ready_pulse: assert property (
    pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_ready: assert property (
    pslverr |-> pready && psel && penable)
    else $error("error outside an access");
endmodule
bind rtc_core rtc_core_monitor #(.DIV(DIV), .PER_SEC(PER_SEC)) u_mon (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .alarm_n(alarm_n),
  .rtc_interrupt_n(rtc_interrupt_n),
  .rtc_interrupt_request(rtc_interrupt_request)
);
`default_nettype wire

/* File: tb/rtc_core_tb.sv */
// self-checking bench for the rtc core
`timescale 1ns/1ps
`default_nettype none
module rtc_core_tb;
  import rtc_pkg::*;
  localparam int DV = 2;
  localparam int PS = 256;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd, s1;
  logic pready, pslverr, alarm_n, rtc_interrupt_n, rtc_interrupt_request;
  logic err;
  int bad_count = 0;
  int n_compared = 0;
  int gap;
  always #50 clk = ~clk;
  rtc_core #(.DIV(DV), .PER_SEC(PS)) u_dut (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .alarm_n(alarm_n),
    .rtc_interrupt_n(rtc_interrupt_n),
    .rtc_interrupt_request(rtc_interrupt_request)
  );
  // ----
  // tasks
  // ----
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      bad_count++;
      test_done();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    check(rd, {24'h000000, e});
  endtask
  task automatic wait_fall();
    logic last;
    last = 1'b0;
    gap = 0;
    while (!(last === 1'b1 && rtc_interrupt_n === 1'b0)) begin
      last = rtc_interrupt_n;
      @(posedge clk);
      gap++;
      if (gap > 3000) begin
        bad_count++;
        test_done();
      end
    end
    check(alarm_n, 1'b0);
    check(rtc_interrupt_request, 1'b1);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_defaults();
    rc(OFF_PAGE_CTRL, PAGE_CTRL_RST);
    rc(OFF_RTC_RESET, {DIS1_RST, DIS16_RST, 6'h00});
    xfer(1'b0, 8'h24, 8'h00);
    check(err, 1'b1);
  endtask
  task automatic t_one_hz();
    wr(OFF_RTC_RESET, 8'h40);
    wr(OFF_SECOND, 8'h05);
    wr(OFF_PAGE_CTRL, 8'h88);
    wait_fall();
    wait_fall();
    check(gap, DV * PS);
    xfer(1'b0, OFF_SECOND, 8'h00);
    s1 = rd;
    rc(OFF_SECOND, s1[7:0]);
    s1 = rd + 1;
    wait_fall();
    rc(OFF_SECOND, s1[7:0]);
  endtask
  task automatic t_stop();
    wait_fall();
    wr(OFF_PAGE_CTRL, 8'h80);
    xfer(1'b0, OFF_SECOND, 8'h00);
    s1 = rd;
    wait_fall();
    rc(OFF_SECOND, s1[7:0]);
    wr(OFF_SECOND, 8'h10);
    wr(OFF_PAGE_CTRL, 8'h88);
    rc(OFF_SECOND, 8'h10);
  endtask
  task automatic t_adjust();
    wr(OFF_PAGE_CTRL, 8'h88);
    for (int i = 0; i < 2; i++) begin
      wait_fall();
      wr(OFF_SECOND, 8'h1d + 8'(i));
      xfer(1'b0, OFF_MINUTE, 8'h00);
      s1 = rd + i;
      wr(OFF_PAGE_CTRL, 8'h98);
      rc(OFF_PAGE_CTRL, 8'h98);
      wait_fall();
      rc(OFF_SECOND, 8'h00);
      rc(OFF_MINUTE, s1[7:0]);
    end
    rc(OFF_PAGE_CTRL, 8'h88);
  endtask
  task automatic t_sec_reset();
    wr(OFF_RTC_RESET, 8'h60);
    wait_fall();
    check(gap >= DV * PS - 4 && gap <= DV * PS + 4, 1'b1);
    wr(OFF_MINUTE, 8'h2a);
    rc(OFF_RTC_RESET, 8'h40);
    rc(OFF_MINUTE, 8'h2a);
  endtask
  task automatic t_sixteen();
    wr(OFF_RTC_RESET, 8'h80);
    wait_fall();
    wait_fall();
    check(gap, DV * PS * LS_PER_16HZ / LS_PER_SEC);
  endtask
  task automatic t_alarm();
    wr(OFF_PAGE_CTRL, 8'h01);
    wr(OFF_RTC_RESET, 8'hd0);
    rc(OFF_MINUTE, 8'(ALM_MIN_RST));
    rc(OFF_HOUR, 8'(ALM_HOUR_RST));
    rc(OFF_DATE, 8'(ALM_DATE_RST));
    rc(OFF_WEEKDAY, 8'(ALM_DAY_RST));
    for (int p = 1; p >= 0; p--) begin
      wr(OFF_PAGE_CTRL, 8'(p));
      wr(OFF_WEEKDAY, 8'h02);
      wr(OFF_DATE, 8'h07);
      wr(OFF_HOUR, 8'h04);
      wr(OFF_MINUTE, 8'h04 + 8'(p));
    end
    wr(OFF_SECOND, 8'h3a);
    wr(OFF_PAGE_CTRL, 8'h0c);
    wr(OFF_PAGE_CTRL, 8'h8c);
    wait_fall();
    check(gap < 3 * DV * PS, 1'b1);
    rc(OFF_MINUTE, 8'h05);
    rc(OFF_SECOND, 8'h00);
    wr(OFF_PAGE_CTRL, 8'h8d);
    wr(OFF_MINUTE, 8'h06);
    rc(OFF_MINUTE, 8'h06);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    t_defaults();
    t_one_hz();
    t_stop();
    t_adjust();
    t_sec_reset();
    t_sixteen();
    t_alarm();
    test_done();
  end
endmodule
`default_nettype wire
